// ---- testbench/pvc_host.sv ----
// bus host model: open-drain data, clock stands high between frames
`timescale 1ns/10ps
module pvc_host
  import pvc_pkg::*;
#(
  parameter int Q = 63
)(
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wq();
    repeat (Q) @(posedge clk);
    #1;
  endtask : wq
  // four quarters of 63 clocks keep each bit just under the top rate
  task automatic bit_x(input logic b, output logic r);
    sda_pull = !b;
    wq();
    scl = 1'b1;
    wq();
    r = sda;
    wq();
    scl = 1'b0;
    wq();
  endtask : bit_x
  task automatic start();
    sda_pull = 1'b0;
    wq();
    scl = 1'b1;
    wq();
    sda_pull = 1'b1;
    wq();
    scl = 1'b0;
    wq();
  endtask : start
  task automatic stop();
    sda_pull = 1'b1;
    wq();
    scl = 1'b1;
    wq();
    sda_pull = 1'b0;
    wq();
  endtask : stop
  task automatic byte_x(input logic [7:0] d, input logic hb, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(hb, r);
  endtask : byte_x
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic r0, r1, r2;
    start();
    byte_x({a, 1'b0}, 1'b1, q, r0);
    byte_x(idx, 1'b1, q, r1);
    byte_x(d, 1'b1, q, r2);
    stop();
    ok = !(r0 | r1 | r2);
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic r0, r1, r2, r3;
    start();
    byte_x({SLAVE_ADDR, 1'b0}, 1'b1, q, r0);
    byte_x(idx, 1'b1, q, r1);
    start();
    byte_x({SLAVE_ADDR, 1'b1}, 1'b1, q, r2);
    byte_x(8'hFF, 1'b1, d, r3);
    stop();
    ok = !(r0 | r1 | r2);
  endtask : rd
endmodule : pvc_host

// ---- testbench/pvc_top_props.sv ----
// port checker for the buck voltage-control slave
`timescale 1ns/10ps
module pvc_top_props
  import pvc_pkg::*;
(
  input wire logic         clk,
  input wire logic         sys_rst,
  input wire logic         serial_clock_pin,
  input wire logic         serial_data_pin_in,
  input wire logic         serial_data_pin_out,
  input wire logic         serial_data_pin_oe,
  input wire logic         over_temp_pin,
  input wire logic         buck_one_enable_pin,
  input wire logic         buck_two_enable_pin,
  input wire logic         adjustable_strap_pin,
  input wire pvc_pwr_out_t pwr,
  input wire logic [6:0]   buck1_setpoint_code,
  input wire logic [6:0]   buck2_setpoint_code,
  input wire logic [6:0]   converter_param_bits
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // reset guard: outputs move during reset and $past still sees that
  property p_bleed; !$past(sys_rst) && $stable(converter_param_bits) |-> pwr.bleed == (converter_param_bits[3:2] & ~pwr.run); endproperty
  a_bleed: assert property (p_bleed) else $error("bleed path wrong");
  property p_en_gate; (!buck_one_enable_pin && !buck_two_enable_pin) [*4] |-> pwr.run == 2'b00; endproperty
  a_en_gate: assert property (p_en_gate) else $error("buck runs while disabled");
  property p_otp_off; over_temp_pin [*4] |-> pwr.run == 2'b00; endproperty
  a_otp_off: assert property (p_otp_off) else $error("buck runs when hot");
  property p_otp_soft; $fell(over_temp_pin) |-> ##[1:4] pwr.soft_start; endproperty
  a_otp_soft: assert property (p_otp_soft) else $error("no soft-start on restart");
  property p_rst_vals; $past(sys_rst) |-> buck1_setpoint_code == SETPOINT_RST && buck2_setpoint_code == SETPOINT_RST
    && converter_param_bits == CONV_PARAM_RST && !pwr.use_reg; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset value wrong");
  property p_use_src; !$past(sys_rst) && $changed(pwr.use_reg) |-> !serial_clock_pin; endproperty
  a_use_src: assert property (p_use_src) else $error("source select moved off bus write");
  property p_sp_bus; !$past(sys_rst) && ($changed(buck1_setpoint_code) || $changed(buck2_setpoint_code)
    || $changed(converter_param_bits)) |-> !serial_clock_pin; endproperty
  a_sp_bus: assert property (p_sp_bus) else $error("register moved off bus write");
  property p_oe_edge; !$past(sys_rst) && $changed(serial_data_pin_oe) |-> !serial_clock_pin; endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("data drive moved with clock high");
  c_hot: cover property (over_temp_pin [*4]);
  c_use: cover property ($rose(pwr.use_reg));
  c_ack: cover property ($rose(serial_data_pin_oe));
endmodule : pvc_top_props
bind pvc_top pvc_top_props u_props (.clk(clk), .sys_rst(sys_rst), .serial_clock_pin(serial_clock_pin),
  .serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe(serial_data_pin_oe), .over_temp_pin(over_temp_pin), .buck_one_enable_pin(buck_one_enable_pin),
  .buck_two_enable_pin(buck_two_enable_pin), .adjustable_strap_pin(adjustable_strap_pin), .pwr(pwr),
  .buck1_setpoint_code(buck1_setpoint_code), .buck2_setpoint_code(buck2_setpoint_code),
  .converter_param_bits(converter_param_bits));

// ---- testbench/tb.sv ----
// self-checking bench for the buck voltage-control slave
`timescale 1ns/10ps
module tb
  import pvc_pkg::*;
;
  logic         clk, sys_rst, over_temp, en1, en2, strap, scl, sda_pull, oe, sda_out;
  pvc_pwr_out_t pwr;
  logic [6:0]   sp1, sp2, cpar;
  int           bad_count = 0;
  int           num_checks = 0;
  wire          sda = !(oe | sda_pull);
  pvc_top dut (.clk(clk), .sys_rst(sys_rst), .serial_clock_pin(scl), .serial_data_pin_in(sda),
    .serial_data_pin_out(sda_out), .serial_data_pin_oe(oe), .over_temp_pin(over_temp), .buck_one_enable_pin(en1),
    .buck_two_enable_pin(en2), .adjustable_strap_pin(strap), .pwr(pwr), .buck1_setpoint_code(sp1),
    .buck2_setpoint_code(sp2), .converter_param_bits(cpar));
  pvc_host host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    num_checks++;
    if (act !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got %h exp %h", $time, act, exp);
    end
  endtask : chk
  task automatic finish_test();
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : do_reset
  task automatic t_reset();
    logic [7:0] d;
    logic ok;
    chk({1'b0, sp1}, {1'b0, SETPOINT_RST});
    chk({1'b0, sp2}, 8'h10);
    chk({6'h0, pwr.bleed}, 8'h03);
    chk({7'h0, pwr.use_reg}, 8'h00);
    chk({7'h0, sda_out}, 8'h00);
    host.rd(IDX_CONV_PARAM, d, ok);
    chk(d, 8'h0F);
    chk({7'h0, ok}, 8'h01);
  endtask : t_reset
  task automatic t_setpoint();
    logic [7:0] d;
    logic ok;
    host.wr(SLAVE_ADDR, IDX_BUCK1_SET, 8'hEF, ok);
    host.wr(SLAVE_ADDR, IDX_BUCK2_SET, 8'h00, ok);
    chk({1'b0, sp1}, 8'h6F);
    chk({1'b0, sp2}, 8'h00);
    chk({7'h0, pwr.use_reg}, 8'h00);
    host.rd(IDX_BUCK1_SET, d, ok);
    chk(d, 8'h6F);
    host.wr(SLAVE_ADDR, IDX_SYS_CTRL, 8'h40, ok);
    chk({7'h0, pwr.use_reg}, 8'h01);
    host.rd(IDX_SYS_CTRL, d, ok);
    chk(d, 8'h40);
  endtask : t_setpoint
  task automatic t_addr();
    logic ok;
    host.wr(SLAVE_ADDR ^ 7'h01, IDX_BUCK1_SET, 8'h22, ok);
    chk({7'h0, ok}, 8'h00);
    chk({1'b0, sp1}, 8'h6F);
  endtask : t_addr
  task automatic t_bleed();
    logic ok;
    host.wr(SLAVE_ADDR, IDX_CONV_PARAM, 8'h0B, ok);
    en1 = 1'b1;
    repeat (6) @(posedge clk);
    #1 chk({4'h0, pwr.run, pwr.bleed}, 8'h06);
    en1 = 1'b0;
    repeat (6) @(posedge clk);
    #1 chk({4'h0, pwr.run, pwr.bleed}, 8'h02);
  endtask : t_bleed
  task automatic t_thermal();
    en1 = 1'b1;
    en2 = 1'b1;
    over_temp = 1'b1;
    repeat (6) @(posedge clk);
    #1 chk({6'h0, pwr.run}, 8'h00);
    over_temp = 1'b0;
    repeat (6) @(posedge clk);
    #1 chk({5'h0, pwr.run, pwr.soft_start}, 8'h07);
    repeat (SOFT_START_CYC + 8) @(posedge clk);
    #1 chk({5'h0, pwr.run, pwr.soft_start}, 8'h06);
  endtask : t_thermal
  task automatic t_adj();
    logic ok;
    strap = 1'b1;
    do_reset();
    chk({1'b0, cpar}, 8'h0F);
    host.wr(SLAVE_ADDR, IDX_SYS_CTRL, 8'h40, ok);
    chk({7'h0, pwr.use_reg}, 8'h00);
  endtask : t_adj
  initial begin
    {over_temp, en1, en2, strap} = 4'h0;
    do_reset();
    t_reset();
    t_setpoint();
    t_addr();
    t_bleed();
    t_thermal();
    t_adj();
    finish_test();
  end
  // the run needs about 75k clocks, so 90k leaves margin without hiding a hang
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    finish_test();
  end
endmodule : tb

// ---- verilog/pvc_pkg.sv ----
// shared constants and carrier types for the buck voltage-control slave
package pvc_pkg;

  // two-wire bus slave identity and direction bit
  localparam logic [6:0] SLAVE_ADDR     = 7'h68;
  localparam logic       DIR_READ       = 1'b1;

  // register indices
  localparam logic [7:0] IDX_BUCK1_SET  = 8'h00;
  localparam logic [7:0] IDX_BUCK2_SET  = 8'h01;
  localparam logic [7:0] IDX_CONV_PARAM = 8'h04;
  localparam logic [7:0] IDX_SYS_CTRL   = 8'h07;

  // reset values and field positions
  localparam logic [6:0] SETPOINT_RST   = 7'h10;
  localparam logic [6:0] CONV_PARAM_RST = 7'h0F;
  localparam int         BLEED1_BIT     = 2;
  localparam int         BLEED2_BIT     = 3;
  localparam int         REG_CTRL_BIT   = 6;

  // bus figures and soft-start duration
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         BUS_MAX_KBPS   = 400;
  localparam int         SOFT_START_NS  = 20000;
  localparam logic [15:0] SOFT_START_CYC = 16'((SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // strap is read two cycles into soft-start, once the pin synchroniser holds real levels
  localparam logic [15:0] STRAP_TAKE_CNT = SOFT_START_CYC - 16'h0002;

  // synchroniser lanes: scl, sda, over-temp, two enables, variant strap
  localparam int         SYNC_W         = 6;

  typedef struct packed {
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
  } pvc_sync_t;

  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_IDX, BUS_IDX_ACK,
    BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RDATA_ACK
  } pvc_bus_state_t;

  typedef enum logic [1:0] {
    PWR_SOFT, PWR_RUN, PWR_SHUT
  } pvc_pwr_state_t;

  // what the converters see
  typedef struct packed {
    logic [1:0] run;
    logic [1:0] bleed;
    logic       soft_start;
    logic       use_reg;
  } pvc_pwr_out_t;

  typedef struct packed {
    pvc_pwr_state_t st;
    logic [15:0]    cnt;
    logic           strap_taken;
    logic           adjustable;
    pvc_pwr_out_t   out;
  } pvc_pwr_reg_t;

  typedef struct packed {
    pvc_bus_state_t st;
    logic [3:0]     bit_cnt;
    logic [7:0]     shreg;
    logic [7:0]     idx;
    logic           rw;
    logic           nack;
    logic           scl_q;
    logic           sda_q;
    logic           sda_oe;
    logic [6:0]     sp1;
    logic [6:0]     sp2;
    logic [6:0]     cparam;
    logic           reg_ctrl;
  } pvc_top_reg_t;

endpackage : pvc_pkg

// ---- verilog/pvc_power_ctl.sv ----
// thermal shutdown, soft-start restart, discharge and voltage-source selection
`timescale 1ns/10ps
module pvc_power_ctl
  import pvc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       over_temp,
  input  wire logic [1:0] enable_req,
  input  wire logic [1:0] discharge_en,
  input  wire logic       reg_ctrl,
  input  wire logic       adjustable_strap,
  output pvc_pwr_out_t    pwr
);

  pvc_pwr_reg_t q;
  pvc_pwr_reg_t next_q;
  logic [1:0]   next_run;

  always_comb begin
    next_q   = q;
    next_run = 2'b00;
    // strap caught once, after the synchroniser has flushed its reset zeros; earlier it always reads 0
    if (!q.strap_taken && q.st == PWR_SOFT && q.cnt == STRAP_TAKE_CNT) begin
      next_q.strap_taken = 1'b1;
      next_q.adjustable  = adjustable_strap;
    end
    case (q.st)
      PWR_SOFT: begin
        next_run = enable_req;
        if (over_temp) begin
          next_q.st = PWR_SHUT;
        end else if (q.cnt == 16'h0000) begin
          next_q.st = PWR_RUN;
        end else begin
          next_q.cnt = q.cnt - 16'h0001;
        end
      end
      PWR_RUN: begin
        next_run = enable_req;
        if (over_temp) begin
          next_q.st = PWR_SHUT;
        end
      end
      default: begin
        // all regulators off until the sensor drops below its lower point
        if (!over_temp) begin
          next_q.st  = PWR_SOFT;
          next_q.cnt = SOFT_START_CYC;
        end
      end
    endcase
    if (over_temp) begin
      next_run = 2'b00;
    end
    next_q.out.run        = next_run;
    next_q.out.bleed      = discharge_en & ~next_run;
    next_q.out.soft_start = (next_q.st == PWR_SOFT);
    // external feedback sets the output on the adjustable variant
    next_q.out.use_reg    = reg_ctrl & ~next_q.adjustable;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q     <= '0;
      q.st  <= PWR_SOFT;
      q.cnt <= SOFT_START_CYC;
    end else begin
      q <= next_q;
    end
  end

  assign pwr = q.out;

endmodule : pvc_power_ctl

// ---- verilog/pvc_sync2.sv ----
// two-flop synchroniser for all asynchronous pins of the block
`timescale 1ns/10ps
module pvc_sync2
  import pvc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [SYNC_W-1:0] async_in,
  output logic      [SYNC_W-1:0] sync_out
);

  pvc_sync_t q;
  pvc_sync_t next_q;

  // stage1 feeds stage2 only; nothing else reads it
  always_comb begin
    next_q        = q;
    next_q.stage1 = async_in;
    next_q.stage2 = q.stage1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sync_out = q.stage2;

endmodule : pvc_sync2

// ---- verilog/pvc_top.sv ----
// two-wire slave with buck setpoint, parameter and system control registers
`timescale 1ns/10ps

module pvc_top
  import pvc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       serial_clock_pin,
  input  wire logic       serial_data_pin_in,
  output logic            serial_data_pin_out,
  output logic            serial_data_pin_oe,
  input  wire logic       over_temp_pin,
  input  wire logic       buck_one_enable_pin,
  input  wire logic       buck_two_enable_pin,
  input  wire logic       adjustable_strap_pin,
  output pvc_pwr_out_t    pwr,
  output logic [6:0]      buck1_setpoint_code,
  output logic [6:0]      buck2_setpoint_code,
  output logic [6:0]      converter_param_bits
);

  pvc_top_reg_t      q;
  pvc_top_reg_t      next_q;
  logic [SYNC_W-1:0] pins_sync;
  logic              scl;
  logic              sda;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_seen;
  logic              stop_seen;
  logic [7:0]        next_idx;

  // every pin passes two flops; at 100 MHz a 400 kb/s bit spans over 200 samples
  pvc_sync2 u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({adjustable_strap_pin, buck_two_enable_pin, buck_one_enable_pin,
                over_temp_pin, serial_data_pin_in, serial_clock_pin}),
    .sync_out (pins_sync)
  );

  assign scl        = pins_sync[0];
  assign sda        = pins_sync[1];
  assign scl_rise   = scl & ~q.scl_q;
  assign scl_fall   = ~scl & q.scl_q;
  assign start_seen = scl & q.scl_q & q.sda_q & ~sda;
  assign stop_seen  = scl & q.scl_q & ~q.sda_q & sda;
  assign next_idx   = q.idx + 8'h01;

  // register read map, used when a read byte is first loaded and when it auto-advances
  function automatic logic [7:0] read_reg(input pvc_top_reg_t r, input logic [7:0] idx);
    logic [7:0] data;
    data = 8'h00;
    if (idx == IDX_BUCK1_SET) begin
      data = {1'b0, r.sp1};
    end else if (idx == IDX_BUCK2_SET) begin
      data = {1'b0, r.sp2};
    end else if (idx == IDX_CONV_PARAM) begin
      data = {1'b0, r.cparam};
    end else if (idx == IDX_SYS_CTRL) begin
      data = {1'b0, r.reg_ctrl, 6'h00};
    end
    return data;
  endfunction : read_reg

  always_comb begin
    next_q       = q;
    next_q.scl_q = scl;
    next_q.sda_q = sda;
    if (start_seen) begin
      // start and repeated start both restart address reception
      next_q.st      = BUS_ADDR;
      next_q.bit_cnt = 4'h0;
      next_q.sda_oe  = 1'b0;
    end else if (stop_seen) begin
      next_q.st     = BUS_IDLE;
      next_q.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (q.st)
        BUS_ADDR, BUS_IDX, BUS_WDATA: begin
          next_q.shreg   = {q.shreg[6:0], sda};
          next_q.bit_cnt = q.bit_cnt + 4'h1;
        end
        BUS_RDATA_ACK: begin
          next_q.nack = sda;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (q.st)
        BUS_ADDR: begin
          if (q.bit_cnt == 4'h8) begin
            if (q.shreg[7:1] == SLAVE_ADDR) begin
              next_q.sda_oe = 1'b1;
              next_q.rw     = q.shreg[0];
              next_q.st     = BUS_ADDR_ACK;
            end else begin
              next_q.st = BUS_IDLE;
            end
          end
        end
        BUS_ADDR_ACK: begin
          next_q.bit_cnt = 4'h0;
          if (q.rw == DIR_READ) begin
            next_q.shreg  = read_reg(q, q.idx);
            next_q.sda_oe = ~next_q.shreg[7];
            next_q.st     = BUS_RDATA;
          end else begin
            next_q.sda_oe = 1'b0;
            next_q.st     = BUS_IDX;
          end
        end
        BUS_IDX: begin
          if (q.bit_cnt == 4'h8) begin
            next_q.idx    = q.shreg;
            next_q.sda_oe = 1'b1;
            next_q.st     = BUS_IDX_ACK;
          end
        end
        BUS_IDX_ACK: begin
          next_q.sda_oe  = 1'b0;
          next_q.bit_cnt = 4'h0;
          next_q.st      = BUS_WDATA;
        end
        BUS_WDATA: begin
          if (q.bit_cnt == 4'h8) begin
            next_q.sda_oe = 1'b1;
            next_q.st     = BUS_WDATA_ACK;
            // reserved bit 7 is dropped; unmapped indices accept and discard
            if (q.idx == IDX_BUCK1_SET) begin
              next_q.sp1 = q.shreg[6:0];
            end else if (q.idx == IDX_BUCK2_SET) begin
              next_q.sp2 = q.shreg[6:0];
            end else if (q.idx == IDX_CONV_PARAM) begin
              next_q.cparam = q.shreg[6:0];
            end else if (q.idx == IDX_SYS_CTRL) begin
              next_q.reg_ctrl = q.shreg[REG_CTRL_BIT];
            end
          end
        end
        BUS_WDATA_ACK: begin
          next_q.sda_oe  = 1'b0;
          next_q.bit_cnt = 4'h0;
          next_q.idx     = next_idx;
          next_q.st      = BUS_WDATA;
        end
        BUS_RDATA: begin
          next_q.bit_cnt = q.bit_cnt + 4'h1;
          if (q.bit_cnt == 4'h7) begin
            // release for the host's acknowledge
            next_q.sda_oe = 1'b0;
            next_q.st     = BUS_RDATA_ACK;
          end else begin
            next_q.shreg  = {q.shreg[6:0], 1'b0};
            next_q.sda_oe = ~q.shreg[6];
          end
        end
        BUS_RDATA_ACK: begin
          if (q.nack) begin
            next_q.sda_oe = 1'b0;
            next_q.st     = BUS_IDLE;
          end else begin
            next_q.idx     = next_idx;
            next_q.shreg   = read_reg(q, next_idx);
            next_q.sda_oe  = ~next_q.shreg[7];
            next_q.bit_cnt = 4'h0;
            next_q.st      = BUS_RDATA;
          end
        end
        default: begin
          next_q.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q          <= '0;
      q.st       <= BUS_IDLE;
      q.scl_q    <= 1'b1;
      q.sda_q    <= 1'b1;
      q.sp1      <= SETPOINT_RST;
      q.sp2      <= SETPOINT_RST;
      q.cparam   <= CONV_PARAM_RST;
      q.reg_ctrl <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  pvc_power_ctl u_power (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .over_temp        (pins_sync[2]),
    .enable_req       (pins_sync[4:3]),
    .discharge_en     ({q.cparam[BLEED2_BIT], q.cparam[BLEED1_BIT]}),
    .reg_ctrl         (q.reg_ctrl),
    .adjustable_strap (pins_sync[5]),
    .pwr              (pwr)
  );

  // open-drain data line: only ever pulled low
  assign serial_data_pin_out  = 1'b0;
  assign serial_data_pin_oe   = q.sda_oe;
  // code passes straight to the linear 25 mV-step reference; codes past 6F are left undefined
  assign buck1_setpoint_code  = q.sp1;
  assign buck2_setpoint_code  = q.sp2;
  assign converter_param_bits = q.cparam;

endmodule : pvc_top
